// *** core/mcop_pkg.sv ***
// Shared constants and types for the math coprocessor register block.
package mcop_pkg;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 32;
   localparam int BE_W = 4;

   // Register byte offsets.
   localparam logic [ADDR_W-1:0] OFF_CTRL = 7'h00;
   localparam logic [ADDR_W-1:0] OFF_STAT = 7'h04;
   localparam logic [ADDR_W-1:0] OFF_MASKED = 7'h08;
   localparam logic [ADDR_W-1:0] OFF_RAW = 7'h0C;
   localparam logic [ADDR_W-1:0] OFF_IEN = 7'h10;
   localparam logic [ADDR_W-1:0] OFF_OPA = 7'h14;
   localparam logic [ADDR_W-1:0] OFF_OPB = 7'h18;
   localparam logic [ADDR_W-1:0] OFF_OPC = 7'h1C;
   localparam logic [ADDR_W-1:0] OFF_RESD = 7'h20;
   localparam logic [ADDR_W-1:0] OFF_BANK = 7'h34;
   localparam logic [ADDR_W-1:0] OFF_REV = 7'h3C;
   localparam logic [ADDR_W-1:0] OFF_INIT = 7'h40;

   // Field positions.
   localparam int RUN_BIT = 0;
   localparam int HWBANK_BIT = 1;
   localparam int BUSY_BIT = 0;
   localparam int DONE_BIT = 0;
   localparam int IEN_BIT = 0;
   localparam int WSEL_BIT = 0;
   localparam int RSEL_BIT = 1;
   localparam int INIT_BIT = 29;
   localparam int REV_MID_LSB = 8;
   localparam int REV_MAJ_LSB = 16;

   // Reset values and write masks.
   localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0078;
   localparam logic [DATA_W-1:0] CTRL_WMASK = 32'h000F_07FE;
   localparam logic [DATA_W-1:0] INIT_RST = 32'h2000_0000;
   localparam logic [DATA_W-1:0] INIT_WMASK = 32'h2000_0000;
   localparam logic [DATA_W-1:0] ZERO_W = 32'h0000_0000;

   typedef struct packed {
      logic [ADDR_W-1:0] address;
      logic read;
      logic write;
      logic [DATA_W-1:0] writedata;
      logic [BE_W-1:0] byteenable;
   } mcop_avreq_t;

   typedef struct packed {
      logic [DATA_W-1:0] a;
      logic [DATA_W-1:0] b;
      logic [DATA_W-1:0] c;
      logic [DATA_W-1:0] d;
   } mcop_regset_t;

   typedef enum logic [1:0] {
      ENG_IDLE = 2'b00,
      ENG_RUN = 2'b01,
      ENG_DONE = 2'b11
   } mcop_eng_state_t;
endpackage

// *** core/mcop_engine.sv ***
// Fixed-latency arithmetic engine that turns operands into sign-extended results.
`timescale 1ns/1ps
module mcop_engine #(
   parameter int OP_CYCLES = 8,
   parameter int RES_W = 16
) (
   input wire logic mclk_i,
   input wire logic arst_n_i,
   input wire logic init_i,
   input wire logic start_i,
   input wire mcop_pkg::mcop_regset_t oper_i,
   output logic busy_o,
   output logic done_o,
   output mcop_pkg::mcop_regset_t res_o
);
   // The counter is eight bits wide, so longer latencies cannot be served.
   if (OP_CYCLES < 1 || OP_CYCLES > 255) begin : g_bad_cycles
      $error("OP_CYCLES out of range");
   end
   if (RES_W < 2 || RES_W > mcop_pkg::DATA_W) begin : g_bad_width
      $error("RES_W out of range");
   end

   localparam logic [7:0] LAST_CNT = 8'(OP_CYCLES - 1);

   // Results are formed narrow and widened from their own sign bit.
   function automatic logic [mcop_pkg::DATA_W-1:0] sext(input logic [RES_W-1:0] v);
      sext = {{(mcop_pkg::DATA_W - RES_W){v[RES_W-1]}}, v};
   endfunction

   mcop_pkg::mcop_eng_state_t state_reg;
   logic [7:0] cnt_reg;
   mcop_pkg::mcop_regset_t oper_reg;
   logic [RES_W-1:0] prod_w;

   assign prod_w = RES_W'(oper_reg.a[RES_W-1:0] * oper_reg.b[RES_W-1:0]);

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_reg <= mcop_pkg::ENG_IDLE;
         cnt_reg <= 8'h00;
      end else if (init_i) begin
         state_reg <= mcop_pkg::ENG_IDLE;
         cnt_reg <= 8'h00;
      end else begin
         unique case (state_reg)
            mcop_pkg::ENG_IDLE: begin
               cnt_reg <= 8'h00;
               if (start_i) state_reg <= mcop_pkg::ENG_RUN;
            end
            mcop_pkg::ENG_RUN: begin
               cnt_reg <= cnt_reg + 8'h01;
               if (cnt_reg == LAST_CNT) state_reg <= mcop_pkg::ENG_DONE;
            end
            mcop_pkg::ENG_DONE: state_reg <= mcop_pkg::ENG_IDLE;
            default: state_reg <= mcop_pkg::ENG_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) oper_reg <= '0;
      else if (start_i && state_reg == mcop_pkg::ENG_IDLE) oper_reg <= oper_i;
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         res_o <= '0;
      end else if (state_reg == mcop_pkg::ENG_RUN && cnt_reg == LAST_CNT) begin
         res_o.a <= sext(oper_reg.a[RES_W-1:0] + oper_reg.b[RES_W-1:0]);
         res_o.b <= sext(oper_reg.a[RES_W-1:0] - oper_reg.b[RES_W-1:0]);
         res_o.c <= sext(oper_reg.c[RES_W-1:0]);
         res_o.d <= sext(prod_w);
      end
   end

   assign busy_o = (state_reg != mcop_pkg::ENG_IDLE);
   assign done_o = (state_reg == mcop_pkg::ENG_DONE);
endmodule

// *** core/mcop_regs.sv ***
// Register block of the math coprocessor with its Avalon-MM slave and interrupt.
//
// Behaviour
// - The raw completion flag sets when an operation finishes whatever the enable says.
// - Writing one to the raw completion flag clears it and writing zero leaves it.
// - With the interrupt enable set a completion raises the interrupt, otherwise not.
// - Three read/write registers hold operands before and results after an operation.
// - A read-only register holds the fourth result and takes no operand.
// - Every result placed in the four data registers is sign-extended to full width.
// - The bank register is hardware-driven and read-only while hardware switching is on.
// - Bank bit zero picks the write bank and bit one the read bank.
// - A read-only revision register holds three byte-wide change counters.
// - Writing one then zero to the initialization bit initializes the coprocessor.
// - The initialization register resets with only its bit set, data registers to zero.
// - The masked completion status is set only when enabled and completed.
// - Writing one to the run bit starts an operation and the bit clears next cycle.
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
module mcop_regs #(
   parameter int OP_CYCLES = 8,
   parameter int RES_W = 16,
   // Revision fields; the values are arbitrary.
   parameter logic [7:0] REV_MINOR = 8'h01,
   parameter logic [7:0] REV_MID = 8'h02,
   parameter logic [7:0] VISIBLE_LOGIC_CHANGE_LEVEL = 8'h03
) (
   input wire logic mclk_i,
   input wire logic arst_n_i,
   input wire mcop_pkg::mcop_avreq_t avs_req_i,
   output logic [mcop_pkg::DATA_W-1:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic irq_o
);
   localparam int NBANK = 2;

   if (OP_CYCLES < 1) begin : g_bad_cycles
      $error("OP_CYCLES must be at least one");
   end

   function automatic logic hit(input logic [mcop_pkg::ADDR_W-1:0] addr,
                                input logic [mcop_pkg::ADDR_W-1:0] off);
      hit = (addr == off);
   endfunction

   // Byte lanes without an enable keep their old contents.
   function automatic logic [mcop_pkg::DATA_W-1:0] be_merge(
      input logic [mcop_pkg::DATA_W-1:0] old_v,
      input logic [mcop_pkg::DATA_W-1:0] new_v,
      input logic [mcop_pkg::BE_W-1:0] be);
      logic [mcop_pkg::DATA_W-1:0] r;
      r = old_v;
      for (int i = 0; i < mcop_pkg::BE_W; i++) begin
         if (be[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
      end
      be_merge = r;
   endfunction

   // Bus handshake: one wait state, then the answer.
   logic ack_reg;
   logic req_w;
   logic wr_fire;
   logic [mcop_pkg::DATA_W-1:0] wdata_w;
   logic [mcop_pkg::BE_W-1:0] be_w;
   logic [mcop_pkg::ADDR_W-1:0] addr_w;

   assign req_w = avs_req_i.read | avs_req_i.write;
   assign avs_waitrequest_o = req_w & ~ack_reg;
   assign wr_fire = avs_req_i.write & ack_reg;
   assign wdata_w = avs_req_i.writedata;
   assign be_w = avs_req_i.byteenable;
   assign addr_w = avs_req_i.address;

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) ack_reg <= 1'b0;
      else ack_reg <= req_w & ~ack_reg;
   end

   // Register state.
   logic [mcop_pkg::DATA_W-1:0] ctrl_reg;
   logic run_reg;
   logic raw_done_reg;
   logic ien_reg;
   logic write_bank_choice_reg;
   logic read_bank_choice_reg;
   logic [mcop_pkg::DATA_W-1:0] init_reg;
   logic init_pulse_reg;
   logic op_bank_reg;
   mcop_pkg::mcop_regset_t bank_mem [NBANK];

   logic eng_busy;
   logic eng_done;
   mcop_pkg::mcop_regset_t eng_res;
   logic hardware_bank_switching;
   logic raw_done_next;
   logic init_fall;

   assign hardware_bank_switching = ctrl_reg[mcop_pkg::HWBANK_BIT];

   // Control register; the run bit lives apart so it can clear itself.
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ctrl_reg <= mcop_pkg::CTRL_RST;
      end else if (wr_fire && hit(addr_w, mcop_pkg::OFF_CTRL)) begin
         ctrl_reg <= be_merge(ctrl_reg, wdata_w, be_w) & mcop_pkg::CTRL_WMASK;
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         run_reg <= 1'b0;
      end else if (wr_fire && hit(addr_w, mcop_pkg::OFF_CTRL) && be_w[0]
                   && wdata_w[mcop_pkg::RUN_BIT]) begin
         run_reg <= 1'b1;
      end else begin
         run_reg <= 1'b0;
      end
   end

   // Initialization: a falling edge of the bit made by a bus write starts it.
   assign init_fall = wr_fire && hit(addr_w, mcop_pkg::OFF_INIT) && be_w[3]
                      && init_reg[mcop_pkg::INIT_BIT] && !wdata_w[mcop_pkg::INIT_BIT];

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         init_reg <= mcop_pkg::INIT_RST;
      end else if (wr_fire && hit(addr_w, mcop_pkg::OFF_INIT)) begin
         init_reg <= be_merge(init_reg, wdata_w, be_w) & mcop_pkg::INIT_WMASK;
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) init_pulse_reg <= 1'b0;
      else init_pulse_reg <= init_fall;
   end

   // Raw completion flag: a completion in the clearing cycle wins.
   always_comb begin
      raw_done_next = raw_done_reg;
      if (wr_fire && hit(addr_w, mcop_pkg::OFF_RAW) && be_w[0]
          && wdata_w[mcop_pkg::DONE_BIT]) begin
         raw_done_next = 1'b0;
      end
      if (eng_done) raw_done_next = 1'b1;
      if (init_pulse_reg) raw_done_next = 1'b0;
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) raw_done_reg <= 1'b0;
      else raw_done_reg <= raw_done_next;
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ien_reg <= 1'b0;
      end else if (wr_fire && hit(addr_w, mcop_pkg::OFF_IEN) && be_w[0]) begin
         ien_reg <= wdata_w[mcop_pkg::IEN_BIT];
      end
   end

   // The level output follows flag and enable, so clearing the flag drops it.
   assign irq_o = raw_done_reg & ien_reg;

   // Bank selection: software owns it only while hardware switching is off.
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         write_bank_choice_reg <= 1'b0;
         read_bank_choice_reg <= 1'b0;
      end else if (init_pulse_reg) begin
         write_bank_choice_reg <= 1'b0;
         read_bank_choice_reg <= 1'b0;
      end else if (hardware_bank_switching) begin
         if (eng_done) begin
            read_bank_choice_reg <= op_bank_reg;
            write_bank_choice_reg <= ~op_bank_reg;
         end
      end else if (wr_fire && hit(addr_w, mcop_pkg::OFF_BANK) && be_w[0]) begin
         write_bank_choice_reg <= wdata_w[mcop_pkg::WSEL_BIT];
         read_bank_choice_reg <= wdata_w[mcop_pkg::RSEL_BIT];
      end
   end

   // Results go back into the bank whose operands started the operation.
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) op_bank_reg <= 1'b0;
      else if (run_reg && !eng_busy) op_bank_reg <= write_bank_choice_reg;
   end

   // Operand/result banks; the fourth word is written only by the engine.
   for (genvar g = 0; g < NBANK; g++) begin : g_bank
      always_ff @(posedge mclk_i or negedge arst_n_i) begin
         if (!arst_n_i) begin
            bank_mem[g] <= '0;
         end else if (init_pulse_reg) begin
            bank_mem[g] <= '0;
         end else if (eng_done && op_bank_reg == 1'(g)) begin
            bank_mem[g] <= eng_res;
         end else if (wr_fire && write_bank_choice_reg == 1'(g)) begin
            if (hit(addr_w, mcop_pkg::OFF_OPA)) begin
               bank_mem[g].a <= be_merge(bank_mem[g].a, wdata_w, be_w);
            end
            if (hit(addr_w, mcop_pkg::OFF_OPB)) begin
               bank_mem[g].b <= be_merge(bank_mem[g].b, wdata_w, be_w);
            end
            if (hit(addr_w, mcop_pkg::OFF_OPC)) begin
               bank_mem[g].c <= be_merge(bank_mem[g].c, wdata_w, be_w);
            end
         end
      end
   end

   mcop_engine #(
      .OP_CYCLES(OP_CYCLES),
      .RES_W(RES_W)
   ) u_engine (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .init_i(init_pulse_reg),
      .start_i(run_reg),
      .oper_i(bank_mem[write_bank_choice_reg]),
      .busy_o(eng_busy),
      .done_o(eng_done),
      .res_o(eng_res)
   );

   // Read path, sampled during the wait state so read data come from flip-flops.
   logic [mcop_pkg::DATA_W-1:0] rdata_next;
   mcop_pkg::mcop_regset_t rbank;

   assign rbank = bank_mem[read_bank_choice_reg];

   always_comb begin
      rdata_next = mcop_pkg::ZERO_W;
      unique case (addr_w)
         mcop_pkg::OFF_CTRL: rdata_next = ctrl_reg;
         mcop_pkg::OFF_STAT: rdata_next[mcop_pkg::BUSY_BIT] = eng_busy | init_pulse_reg;
         mcop_pkg::OFF_MASKED: rdata_next[mcop_pkg::DONE_BIT] = raw_done_reg & ien_reg;
         mcop_pkg::OFF_RAW: rdata_next[mcop_pkg::DONE_BIT] = raw_done_reg;
         mcop_pkg::OFF_IEN: rdata_next[mcop_pkg::IEN_BIT] = ien_reg;
         mcop_pkg::OFF_OPA: rdata_next = rbank.a;
         mcop_pkg::OFF_OPB: rdata_next = rbank.b;
         mcop_pkg::OFF_OPC: rdata_next = rbank.c;
         mcop_pkg::OFF_RESD: rdata_next = rbank.d;
         mcop_pkg::OFF_BANK: begin
            rdata_next[mcop_pkg::WSEL_BIT] = write_bank_choice_reg;
            rdata_next[mcop_pkg::RSEL_BIT] = read_bank_choice_reg;
         end
         mcop_pkg::OFF_REV: begin
            rdata_next[7:0] = REV_MINOR;
            rdata_next[mcop_pkg::REV_MID_LSB +: 8] = REV_MID;
            rdata_next[mcop_pkg::REV_MAJ_LSB +: 8] = VISIBLE_LOGIC_CHANGE_LEVEL;
         end
         mcop_pkg::OFF_INIT: rdata_next = init_reg;
         default: rdata_next = mcop_pkg::ZERO_W;
      endcase
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         avs_readdata_o <= mcop_pkg::ZERO_W;
      end else if (avs_req_i.read && !ack_reg) begin
         avs_readdata_o <= rdata_next;
      end
   end
endmodule

// *** dv/mcop_regs_assertions.sv ***
// Port assertions for the coprocessor register block.
`timescale 1ns/1ps
module mcop_regs_assertions #(
   parameter int OP_CYCLES = 8,
   parameter int RES_W = 16,
   parameter logic [7:0] REV_MINOR = 8'h01,
   parameter logic [7:0] REV_MID = 8'h02,
   parameter logic [7:0] VISIBLE_LOGIC_CHANGE_LEVEL = 8'h03
) (
   input wire logic mclk_i,
   input wire logic arst_n_i,
   input wire mcop_pkg::mcop_avreq_t avs_req_i,
   input wire logic [mcop_pkg::DATA_W-1:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic irq_o
);
   logic rd_first;
   logic wr_done;
   assign rd_first = avs_req_i.read && avs_waitrequest_o;
   assign wr_done = avs_req_i.write && !avs_waitrequest_o;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!arst_n_i);
   AST_ONE_WAIT: assert property (
      (avs_req_i.read || avs_req_i.write) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("waitrequest held beyond one cycle");
   AST_MASKED_READ: assert property (
      rd_first && avs_req_i.address == mcop_pkg::OFF_MASKED
      |=> avs_readdata_o == {{31{1'b0}}, $past(irq_o)})
      else $error("masked status differs from interrupt");
   AST_REV_READ: assert property (
      rd_first && avs_req_i.address == mcop_pkg::OFF_REV
      |=> avs_readdata_o == {8'h00, VISIBLE_LOGIC_CHANGE_LEVEL, REV_MID, REV_MINOR})
      else $error("revision read wrong");
   AST_RUN_READS_ZERO: assert property (
      rd_first && avs_req_i.address == mcop_pkg::OFF_CTRL |=> !avs_readdata_o[0])
      else $error("run bit read as one");
   AST_BANK_UPPER: assert property (
      rd_first && avs_req_i.address == mcop_pkg::OFF_BANK |=> avs_readdata_o[31:2] == '0)
      else $error("bank upper bits not zero");
   AST_CLEAR_DROPS: assert property (
      wr_done && avs_req_i.address == mcop_pkg::OFF_RAW && avs_req_i.writedata[0]
      && avs_req_i.byteenable[0] |=> !irq_o)
      else $error("interrupt stayed after clear");
   AST_DISABLE_DROPS: assert property (
      wr_done && avs_req_i.address == mcop_pkg::OFF_IEN && !avs_req_i.writedata[0]
      && avs_req_i.byteenable[0] |=> !irq_o)
      else $error("interrupt stayed after disable");
   AST_FALL_CAUSE: assert property (
      $fell(irq_o) |-> $past(wr_done) || $past(wr_done, 2) || $past(wr_done, 3))
      else $error("interrupt fell without a write");
endmodule
bind mcop_regs mcop_regs_assertions #(.OP_CYCLES(OP_CYCLES), .RES_W(RES_W),
   .REV_MINOR(REV_MINOR), .REV_MID(REV_MID),
   .VISIBLE_LOGIC_CHANGE_LEVEL(VISIBLE_LOGIC_CHANGE_LEVEL)) u_chk (.mclk_i(mclk_i),
   .arst_n_i(arst_n_i), .avs_req_i(avs_req_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o));

// *** dv/mcop_host_model.sv ***
// Host processor model issuing register transfers on the bus.
`timescale 1ns/1ps
module mcop_host_model (
   input wire logic mclk_i,
   input wire logic [mcop_pkg::DATA_W-1:0] rdata_i,
   input wire logic wait_i,
   output mcop_pkg::mcop_avreq_t avs_req_o
);
   initial avs_req_o = '0;
   // Enter just after a rising edge; an extra edge after release keeps strobes apart.
   task automatic xfer(input logic wr, input logic [6:0] a, input logic [31:0] d,
      input logic [3:0] be, output logic [31:0] q);
      avs_req_o <= {a, ~wr, wr, d, be};
      do @(posedge mclk_i); while (wait_i);
      q = rdata_i;
      avs_req_o <= '0;
      @(posedge mclk_i);
   endtask
endmodule

// *** dv/mcop_regs_test.sv ***
// Self-checking bench for the coprocessor register block.
`timescale 1ns/1ps
module mcop_regs_test;
   logic mclk_i = 1'b0;
   logic arst_n_i = 1'b0;
   mcop_pkg::mcop_avreq_t req;
   logic [31:0] rdata;
   logic waitreq;
   logic irq;
   logic [31:0] q;
   int mismatches = 0;
   int comparisons = 0;
   always #50 mclk_i = ~mclk_i;
   mcop_regs #(.OP_CYCLES(4)) uut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .avs_req_i(req),
      .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .irq_o(irq));
   mcop_host_model host (.mclk_i(mclk_i), .rdata_i(rdata), .wait_i(waitreq),
      .avs_req_o(req));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, 4'hF, q);
   endtask
   task automatic rdc(input logic [6:0] a, input logic [31:0] exp);
      host.xfer(1'b0, a, 32'h0000_0000, 4'h0, q);
      chk(q, exp);
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic reset_values;
      logic [6:0] offs [6] = '{mcop_pkg::OFF_RAW, mcop_pkg::OFF_IEN, mcop_pkg::OFF_OPA,
         mcop_pkg::OFF_OPB, mcop_pkg::OFF_OPC, mcop_pkg::OFF_RESD};
      foreach (offs[i]) rdc(offs[i], 32'h0000_0000);
      rdc(mcop_pkg::OFF_INIT, 32'h2000_0000);
      rdc(mcop_pkg::OFF_REV, 32'h0003_0201);
      rdc(mcop_pkg::OFF_CTRL, 32'h0000_0078);
      rdc(mcop_pkg::OFF_BANK, 32'h0000_0000);
      rdc(7'h7C, 32'h0000_0000);
   endtask
   task automatic access_kinds;
      wr(mcop_pkg::OFF_OPA, 32'hFFFF_FFFF);
      rdc(mcop_pkg::OFF_OPA, 32'hFFFF_FFFF);
      wr(mcop_pkg::OFF_RESD, 32'h1234_5678);
      rdc(mcop_pkg::OFF_RESD, 32'h0000_0000);
      wr(mcop_pkg::OFF_REV, 32'h0000_0000);
      rdc(mcop_pkg::OFF_REV, 32'h0003_0201);
      wr(mcop_pkg::OFF_BANK, 32'h0000_0003);
      rdc(mcop_pkg::OFF_BANK, 32'h0000_0003);
      wr(mcop_pkg::OFF_BANK, 32'h0000_0000);
      rdc(mcop_pkg::OFF_BANK, 32'h0000_0000);
   endtask
   task automatic run_op(input logic [31:0] ctrl);
      int n;
      n = 0;
      wr(mcop_pkg::OFF_CTRL, ctrl);
      rdc(mcop_pkg::OFF_STAT, 32'h0000_0001);
      do begin
         host.xfer(1'b0, mcop_pkg::OFF_RAW, 32'h0000_0000, 4'h0, q);
         n++;
      end while (q[0] !== 1'b1 && n < 30);
      chk(q, 32'h0000_0001);
      rdc(mcop_pkg::OFF_STAT, 32'h0000_0000);
   endtask
   task automatic op_no_irq;
      wr(mcop_pkg::OFF_IEN, 32'h0000_0000);
      wr(mcop_pkg::OFF_OPA, 32'h0000_7FFF);
      wr(mcop_pkg::OFF_OPB, 32'h0000_0001);
      wr(mcop_pkg::OFF_OPC, 32'hFFFF_8000);
      run_op(32'h0000_0079);
      chk({31'h0, irq}, 32'h0000_0000);
      rdc(mcop_pkg::OFF_MASKED, 32'h0000_0000);
      rdc(mcop_pkg::OFF_OPA, 32'hFFFF_8000);
      rdc(mcop_pkg::OFF_OPB, 32'h0000_7FFE);
      rdc(mcop_pkg::OFF_OPC, 32'hFFFF_8000);
      rdc(mcop_pkg::OFF_RESD, 32'h0000_7FFF);
   endtask
   task automatic clear_flag;
      wr(mcop_pkg::OFF_RAW, 32'h0000_0000);
      rdc(mcop_pkg::OFF_RAW, 32'h0000_0001);
      wr(mcop_pkg::OFF_RAW, 32'h0000_0001);
      rdc(mcop_pkg::OFF_RAW, 32'h0000_0000);
   endtask
   task automatic op_irq;
      // The flag is already clear, so enabling cannot raise a stale interrupt.
      wr(mcop_pkg::OFF_IEN, 32'h0000_0001);
      chk({31'h0, irq}, 32'h0000_0000);
      run_op(32'h0000_0079);
      chk({31'h0, irq}, 32'h0000_0001);
      rdc(mcop_pkg::OFF_MASKED, 32'h0000_0001);
      repeat (3) @(posedge mclk_i);
      chk({31'h0, irq}, 32'h0000_0001);
      wr(mcop_pkg::OFF_RAW, 32'h0000_0001);
      chk({31'h0, irq}, 32'h0000_0000);
   endtask
   task automatic hw_bank;
      wr(mcop_pkg::OFF_CTRL, 32'h0000_007A);
      wr(mcop_pkg::OFF_BANK, 32'h0000_0003);
      rdc(mcop_pkg::OFF_BANK, 32'h0000_0000);
      // Hardware switching must stay on during the run, so the run write keeps bit one.
      run_op(32'h0000_007B);
      rdc(mcop_pkg::OFF_BANK, 32'h0000_0001);
      wr(mcop_pkg::OFF_CTRL, 32'h0000_0078);
      wr(mcop_pkg::OFF_RAW, 32'h0000_0001);
      wr(mcop_pkg::OFF_BANK, 32'h0000_0000);
      rdc(mcop_pkg::OFF_BANK, 32'h0000_0000);
   endtask
   task automatic init_seq;
      wr(mcop_pkg::OFF_OPA, 32'h0000_1234);
      wr(mcop_pkg::OFF_INIT, 32'h2000_0000);
      wr(mcop_pkg::OFF_INIT, 32'h0000_0000);
      repeat (2) @(posedge mclk_i);
      rdc(mcop_pkg::OFF_OPA, 32'h0000_0000);
      rdc(mcop_pkg::OFF_INIT, 32'h0000_0000);
   endtask
   initial begin
      repeat (3000) @(posedge mclk_i);
      mismatches++;
      summarize();
   end
   initial begin
      repeat (5) @(posedge mclk_i);
      arst_n_i <= 1'b1;
      @(posedge mclk_i);
      reset_values();
      access_kinds();
      op_no_irq();
      clear_flag();
      op_irq();
      hw_bank();
      init_seq();
      summarize();
   end
endmodule
